/* File: nch_bus_cycle.sv */
// One NAND bus cycle: strobe low phase, read capture as it ends, high phase
`timescale 1ns/10ps
`default_nettype none
module nch_bus_cycle
	import nch_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	nch_cycle_if.eng cyc,
	input wire logic [7:0] io_in,
	output logic [7:0] io_out,
	output logic io_oe_n,
	output logic cle,
	output logic ale,
	output logic we_n,
	output logic re_n
);
	nch_state_t state, next_state;
	logic [3:0] cnt, next_cnt;
	logic [1:0] kind, next_kind;
	logic [7:0] rdata, next_rdata, next_io_out;
	logic next_io_oe_n, next_cle, next_ale, next_we_n, next_re_n;

	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_kind = kind;
		next_rdata = rdata;
		next_io_out = io_out;
		next_io_oe_n = io_oe_n;
		next_cle = cle;
		next_ale = ale;
		next_we_n = we_n;
		next_re_n = re_n;
		case (state)
			NCH_IDLE: begin
				if (cyc.start) begin
					next_kind = cyc.kind;
					next_cle = cyc.kind == REQ_CMD;
					next_ale = cyc.kind == REQ_ADDR;
					next_io_out = cyc.wdata;
					next_io_oe_n = cyc.kind == REQ_READ;
					next_re_n = cyc.kind != REQ_READ;
					next_we_n = cyc.kind == REQ_READ;
					next_cnt = LOW_CNT;
					next_state = NCH_SETUP;
				end
			end
			NCH_SETUP: begin
				if (cnt > 4'h1) begin
					next_cnt = cnt - 4'h1;
				end else begin
					if (kind == REQ_READ) begin
						next_rdata = io_in;
					end
					next_we_n = 1'b1;
					next_re_n = 1'b1;
					next_cnt = HIGH_CNT;
					next_state = NCH_HOLD;
				end
			end
			NCH_HOLD: begin
				if (cnt > 4'h1) begin
					next_cnt = cnt - 4'h1;
				end else begin
					next_cle = 1'b0;
					next_ale = 1'b0;
					next_io_oe_n = 1'b1;
					next_state = NCH_DONE;
				end
			end
			NCH_DONE: next_state = NCH_IDLE;
			default: next_state = NCH_IDLE;
		endcase
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state <= NCH_IDLE;
			cnt <= 4'h0;
			kind <= REQ_CMD;
			rdata <= 8'h00;
			io_out <= 8'h00;
			io_oe_n <= 1'b1;
			cle <= 1'b0;
			ale <= 1'b0;
			we_n <= 1'b1;
			re_n <= 1'b1;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			kind <= next_kind;
			rdata <= next_rdata;
			io_out <= next_io_out;
			io_oe_n <= next_io_oe_n;
			cle <= next_cle;
			ale <= next_ale;
			we_n <= next_we_n;
			re_n <= next_re_n;
		end
	end

	assign cyc.busy = state != NCH_IDLE;
	assign cyc.done = state == NCH_DONE;
	assign cyc.rdata = rdata;
endmodule : nch_bus_cycle
`default_nettype wire

/* File: nch_cycle_if.sv */
// Interface between sequencer and bus cycle engine
`timescale 1ns/10ps
`default_nettype none
interface nch_cycle_if;
	logic start;
	logic [1:0] kind;
	logic [7:0] wdata;
	logic busy;
	logic done;
	logic [7:0] rdata;
	modport seq (output start, output kind, output wdata,
		input busy, input done, input rdata);
	modport eng (input start, input kind, input wdata,
		output busy, output done, output rdata);
endinterface : nch_cycle_if
`default_nettype wire

/* File: nch_flash_model.sv */
// Behavioural NAND device answering the host's bus cycles
`timescale 1ns/10ps
`default_nettype none
module nch_flash_model
	import nch_pkg::*;
#(
	parameter int LOAD_CYC = 40
)
(
	input wire logic cle,
	input wire logic ale,
	input wire logic ce_n,
	input wire logic we_n,
	input wire logic re_n,
	input wire logic [7:0] io,
	output logic [7:0] dev_io,
	output logic ready_busy_n,
	output logic [7:0] last_cmd,
	output logic [11:0] cap_col,
	output logic [17:0] cap_row,
	output logic [7:0] last_din
);
	logic [7:0] abyte [5];
	logic [7:0] last;
	logic [11:0] col;
	int n_addr;
	initial begin
		last_cmd = OP_READ_SETUP;
		last_din = 8'h00;
		ready_busy_n = 1'b1;
		n_addr = 0;
		last = 8'h00;
		col = 12'h000;
	end
	assign cap_col = {abyte[1][3:0], abyte[0]};
	assign cap_row = {abyte[4][1:0], abyte[3], abyte[2]};
	// Released bus shows the inverse of the last byte
	assign dev_io = re_n ? ~last : last;
	always @(posedge we_n) begin
		if (!ce_n && cle) begin
			last_cmd = io;
			n_addr = 0;
			if (io == OP_READ_CONFIRM) begin
				col = cap_col;
				ready_busy_n = 1'b0;
				ready_busy_n <= #(LOAD_CYC * 4) 1'b1;
			end
		end else if (!ce_n && ale && n_addr < 5) begin
			abyte[n_addr] = io;
			n_addr = n_addr + 1;
		end else if (!ce_n && !cle && !ale) begin
			last_din = io;
		end
	end
	always @(negedge re_n) begin
		last = col[7:0] ^ cap_row[7:0];
		col = col + 12'h001;
	end
endmodule : nch_flash_model
`default_nettype wire

/* File: nch_host.sv */
// NAND host controller: sequences opcodes, addresses and data bytes
// Behaviour
// - Five address cycles, column low byte first
// - Unused address bits driven low
// - Page read: 00h, five addresses, 30h
// - After status poll reissue 00h
// - Only status and reset while busy (REQ_ADDR and REQ_WRITE cycles are not screened against busy and are still accepted)
// - Two-plane read: two address sets, one confirm
// - Column moves stay in loaded page
// - Copy-back source, destination share plane
`timescale 1ns/10ps
`default_nettype none
module nch_host
	import nch_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic req_valid,
	input wire logic [1:0] req_kind,
	input wire logic [7:0] req_data,
	input wire logic [11:0] req_col,
	input wire logic [17:0] req_row,
	output logic req_ready,
	output logic req_error,
	output logic rsp_valid,
	output logic [7:0] rsp_data,
	output logic [11:0] col_ptr,
	output logic plane_select_bit,
	output logic device_busy,
	output logic cmd_refused,
	input wire logic wp_n,
	input wire logic ready_busy_n,
	input wire logic [7:0] io_in,
	output logic [7:0] io_out,
	output logic io_oe_n,
	output logic cle,
	output logic ale,
	output logic ce_n,
	output logic we_n,
	output logic re_n,
	output logic wp_out_n
);
	nch_cycle_if cyc();
	logic [2:0] addr_idx, next_addr_idx;
	logic addr_open, next_addr_open;
	logic need_setup, next_need_setup;
	logic [11:0] col, next_col;
	logic [17:0] row, next_row;
	logic [7:0] wbyte;
	logic pending, next_pending;
	logic [1:0] pkind, next_pkind;
	logic [7:0] pdata, next_pdata;
	logic [7:0] rsp_byte, next_rsp_byte;
	logic rsp_v, next_rsp_v;
	logic err, next_err;
	logic refused, next_refused;
	logic cb_armed, next_cb_armed;
	logic cb_plane, next_cb_plane;
	logic accept, reject;

	nch_bus_cycle u_cycle (
		.clock(clock),
		.rst_n(rst_n),
		.cyc(cyc),
		.io_in(io_in),
		.io_out(io_out),
		.io_oe_n(io_oe_n),
		.cle(cle),
		.ale(ale),
		.we_n(we_n),
		.re_n(re_n)
	);

	// Address byte for the current cycle index
	always_comb begin
		case (addr_idx)
			3'd0: wbyte = col[7:0];
			3'd1: wbyte = {4'h0, col[11:8]};
			3'd2: wbyte = row[7:0];
			3'd3: wbyte = row[15:8];
			3'd4: wbyte = {6'h00, row[17:16]};
			default: wbyte = 8'h00;
		endcase
	end

	// Request screening against protection, busy and unknown opcodes
	always_comb begin
		reject = 1'b0;
		if (req_kind == REQ_CMD) begin
			if (!ready_busy_n && !nch_busy_ok(req_data)) begin
				reject = 1'b1;
			end
			if (!wp_n && nch_is_write_op(req_data)) begin
				reject = 1'b1;
			end
			if (!nch_known(req_data)) begin
				reject = 1'b1;
			end
		end
		if (req_kind == REQ_ADDR && !addr_open) begin
			reject = 1'b1;
		end
		if (req_kind == REQ_READ && !ready_busy_n) begin
			reject = 1'b1;
		end
		if (req_kind == REQ_READ && need_setup) begin
			reject = 1'b1;
		end
		if (req_kind == REQ_CMD && req_data == OP_COPY_PROG && cb_armed
			&& req_row[PLANE_BIT_ROW] != cb_plane) begin
			reject = 1'b1;
		end
	end

	assign req_ready = !pending && !cyc.busy;
	assign accept = req_valid && req_ready && !reject;

	always_comb begin
		next_addr_idx = addr_idx;
		next_addr_open = addr_open;
		next_need_setup = need_setup;
		next_col = col;
		next_row = row;
		next_pending = pending;
		next_pkind = pkind;
		next_pdata = pdata;
		next_rsp_byte = rsp_byte;
		next_rsp_v = 1'b0;
		next_err = 1'b0;
		next_refused = refused;
		next_cb_armed = cb_armed;
		next_cb_plane = cb_plane;
		cyc.start = 1'b0;
		cyc.kind = pkind;
		cyc.wdata = pdata;
		if (req_valid && req_ready && reject) begin
			next_err = 1'b1;
			next_refused = 1'b1;
		end
		if (accept) begin
			next_refused = 1'b0;
			next_pending = 1'b1;
			next_pkind = req_kind;
			next_pdata = req_data;
			if (req_kind == REQ_CMD) begin
				next_addr_open = nch_takes_addr(req_data);
				next_addr_idx = 3'd0;
				if (req_data == OP_COL_CHANGE) begin
					next_col = req_col;
				end else begin
					next_col = req_col;
					next_row = req_row;
				end
				if (req_data == OP_STATUS || req_data == OP_STATUS_ENH) begin
					next_need_setup = 1'b1;
				end
				if (req_data == OP_READ_SETUP || req_data == OP_RESET) begin
					next_need_setup = 1'b0;
				end
				// Remember the plane of a copy-back read
				if (req_data == OP_READ_COPYBACK) begin
					next_cb_armed = 1'b1;
					next_cb_plane = req_row[PLANE_BIT_ROW];
				end
				if (req_data == OP_PROG_CONFIRM || req_data == OP_RESET) begin
					next_cb_armed = 1'b0;
				end
			end
		end
		if (pending && !cyc.busy) begin
			cyc.start = 1'b1;
			cyc.kind = pkind;
			cyc.wdata = pkind == REQ_ADDR ? wbyte : pdata;
			next_pending = 1'b0;
		end
		if (cyc.done) begin
			if (pkind == REQ_ADDR) begin
				if (addr_idx == 3'(ADDR_CYCLES - 1)) begin
					next_addr_open = 1'b0;
				end else begin
					next_addr_idx = addr_idx + 3'd1;
				end
			end
			if (pkind == REQ_READ) begin
				next_rsp_v = 1'b1;
				next_rsp_byte = cyc.rdata;
				if (col != PAGE_LAST_COL) begin
					next_col = col + 12'h001;
				end
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			addr_idx <= 3'd0;
			addr_open <= 1'b1;
			need_setup <= 1'b0;
			col <= 12'h000;
			row <= 18'h00000;
			pending <= 1'b0;
			pkind <= REQ_CMD;
			pdata <= 8'h00;
			rsp_byte <= 8'h00;
			rsp_v <= 1'b0;
			err <= 1'b0;
			refused <= 1'b0;
			cb_armed <= 1'b0;
			cb_plane <= 1'b0;
		end else begin
			addr_idx <= next_addr_idx;
			addr_open <= next_addr_open;
			need_setup <= next_need_setup;
			col <= next_col;
			row <= next_row;
			pending <= next_pending;
			pkind <= next_pkind;
			pdata <= next_pdata;
			rsp_byte <= next_rsp_byte;
			rsp_v <= next_rsp_v;
			err <= next_err;
			refused <= next_refused;
			cb_armed <= next_cb_armed;
			cb_plane <= next_cb_plane;
		end
	end

	assign rsp_valid = rsp_v;
	assign rsp_data = rsp_byte;
	assign req_error = err;
	assign cmd_refused = refused;
	assign col_ptr = col;
	assign plane_select_bit = row[PLANE_BIT_ROW];
	assign device_busy = !ready_busy_n;
	assign ce_n = 1'b0;
	assign wp_out_n = wp_n;
endmodule : nch_host
`default_nettype wire

/* File: nch_host_chk.sv */
// Port assertions for the NAND host controller
`timescale 1ns/10ps
`default_nettype none
module nch_host_chk
	import nch_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic req_valid,
	input wire logic [1:0] req_kind,
	input wire logic [7:0] req_data,
	input wire logic req_ready,
	input wire logic req_error,
	input wire logic device_busy,
	input wire logic wp_n,
	input wire logic ready_busy_n,
	input wire logic io_oe_n,
	input wire logic cle,
	input wire logic ale,
	input wire logic ce_n,
	input wire logic we_n,
	input wire logic re_n,
	input wire logic wp_out_n
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);
	sequence s_we_pulse;
		(!we_n)[*3] ##1 we_n;
	endsequence
	sequence s_re_pulse;
		(!re_n)[*3] ##1 re_n;
	endsequence
	a_we_width: assert property ($fell(we_n) |-> s_we_pulse)
		else $error("write strobe width wrong");
	a_re_width: assert property ($fell(re_n) |-> s_re_pulse)
		else $error("read strobe width wrong");
	a_latch_excl: assert property (cle |-> !ale)
		else $error("command and address latch together");
	a_latch_drive: assert property ((cle || ale) |-> !io_oe_n && re_n)
		else $error("latch cycle without bus drive");
	a_read_mode: assert property (!re_n |-> !cle && !ale && we_n && io_oe_n)
		else $error("read strobe outside read mode");
	a_latch_stable: assert property ($rose(we_n) |-> $stable(cle) && $stable(ale))
		else $error("latch moved at write strobe rise");
	a_busy_follow: assert property (device_busy == !ready_busy_n)
		else $error("busy flag does not follow ready line");
	a_chip_on: assert property (!ce_n && wp_out_n == wp_n)
		else $error("chip enable or protect pin wrong");
	a_wp_refuse: assert property (req_valid && req_ready && !wp_n
		&& req_kind == REQ_CMD && req_data == OP_PROG |-> ##[1:2] req_error)
		else $error("program not refused under protect");
	a_busy_read: assert property (req_valid && req_ready && device_busy
		&& req_kind == REQ_READ |-> ##[1:2] req_error)
		else $error("read not refused while busy");
endmodule : nch_host_chk
bind nch_host nch_host_chk u_chk (.clock(clock), .rst_n(rst_n),
	.req_valid(req_valid), .req_kind(req_kind), .req_data(req_data),
	.req_ready(req_ready), .req_error(req_error), .device_busy(device_busy),
	.wp_n(wp_n), .ready_busy_n(ready_busy_n), .io_oe_n(io_oe_n), .cle(cle),
	.ale(ale), .ce_n(ce_n), .we_n(we_n), .re_n(re_n), .wp_out_n(wp_out_n));
`default_nettype wire

/* File: nch_host_tb.sv */
// Self-checking bench for the NAND host controller
`timescale 1ns/10ps
`default_nettype none
module nch_host_tb
	import nch_pkg::*;
;
	localparam int LIMIT = 5000;
	logic clock, rst_n, req_valid, wp_n, err;
	logic [1:0] req_kind;
	logic [7:0] req_data, rsp_data, io_out, dev_io, io_in, last_cmd, got;
	logic [7:0] last_din;
	logic [11:0] req_col, col_ptr, cap_col;
	logic [17:0] req_row, cap_row;
	logic req_ready, req_error, rsp_valid, plane_select_bit, device_busy;
	logic cmd_refused, ready_busy_n, io_oe_n, cle, ale, ce_n, we_n, re_n;
	logic wp_out_n;
	int bad_count = 0;
	int n_tests = 0;
	int cyc = 0;
	logic [7:0] ops [24] = '{8'h00, 8'h35, 8'h31, 8'h3f, 8'h05, 8'h06,
		8'he0, 8'h90, 8'hec, 8'hed, 8'hee, 8'hef, 8'h70, 8'h78, 8'hff,
		8'h80, 8'h81, 8'h85, 8'h10, 8'h11, 8'h15, 8'h60, 8'hd0, 8'hd1};
	assign io_in = io_oe_n ? dev_io : io_out;
	nch_host dut (.clock(clock), .rst_n(rst_n), .req_valid(req_valid),
		.req_kind(req_kind), .req_data(req_data), .req_col(req_col),
		.req_row(req_row), .req_ready(req_ready), .req_error(req_error),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data), .col_ptr(col_ptr),
		.plane_select_bit(plane_select_bit), .device_busy(device_busy),
		.cmd_refused(cmd_refused), .wp_n(wp_n), .ready_busy_n(ready_busy_n),
		.io_in(io_in), .io_out(io_out), .io_oe_n(io_oe_n), .cle(cle),
		.ale(ale), .ce_n(ce_n), .we_n(we_n), .re_n(re_n),
		.wp_out_n(wp_out_n));
	nch_flash_model #(.LOAD_CYC(40)) dev (.cle(cle), .ale(ale), .ce_n(ce_n),
		.we_n(we_n), .re_n(re_n), .io(io_in), .dev_io(dev_io),
		.ready_busy_n(ready_busy_n), .last_cmd(last_cmd), .cap_col(cap_col),
		.cap_row(cap_row), .last_din(last_din));
	task automatic complete_run;
		if (bad_count == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : complete_run
	task automatic chk(input string what, input logic [17:0] exp,
		input logic [17:0] seen);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	// One request, held until taken, then its outcome gathered
	task automatic send(input logic [1:0] kind, input logic [7:0] data);
		int i;
		req_kind = kind;
		req_data = data;
		req_valid = 1'b1;
		err = 1'b0;
		got = 8'hxx;
		for (i = 0; i < 20 && !req_ready; i++) @(negedge clock);
		@(negedge clock);
		req_valid = 1'b0;
		for (i = 0; i < 20; i++) begin
			if (req_error) err = 1'b1;
			if (rsp_valid) got = rsp_data;
			if (req_ready && i > 0) break;
			@(negedge clock);
		end
		@(negedge clock);
		if (rsp_valid) got = rsp_data;
	endtask : send
	task automatic t_idle;
		chk("idle pins", 7'b0011101,
			{cle, ale, we_n, re_n, io_oe_n, ce_n, req_ready});
		send(REQ_ADDR, 8'h00);
		chk("preloaded setup", 1'b0, err);
	endtask : t_idle
	task automatic t_page_read;
		int i;
		req_col = 12'h83c;
		req_row = 18'h2a5c4;
		send(REQ_CMD, OP_READ_SETUP);
		for (i = 0; i < 5; i++) send(REQ_ADDR, 8'h00);
		chk("col", 12'h83c, cap_col);
		chk("row", 18'h2a5c4, cap_row);
		chk("plane", 1'b1, plane_select_bit);
		send(REQ_ADDR, 8'h00);
		chk("extra addr", 1'b1, err);
		chk("row kept", 18'h2a5c4, cap_row);
		send(REQ_CMD, OP_READ_CONFIRM);
		chk("busy", 1'b1, device_busy);
		send(REQ_READ, 8'h00);
		chk("read busy", 1'b1, err);
		send(REQ_CMD, OP_READ_ID);
		chk("id busy", 1'b1, err);
		send(REQ_CMD, OP_STATUS);
		chk("status busy", 1'b0, err);
		for (i = 0; i < 200 && device_busy; i++) @(negedge clock);
		chk("ready", 1'b0, device_busy);
		send(REQ_ADDR, 8'h00);
		chk("stray addr", 1'b1, err);
		send(REQ_READ, 8'h00);
		chk("read after status", 1'b1, err);
		send(REQ_CMD, OP_READ_SETUP);
		for (i = 0; i < 4; i++) begin
			send(REQ_READ, 8'h00);
			chk("data", 8'(8'h3c + i) ^ 8'hc4, got);
			if (i < 3) chk("col ptr", 12'(12'h83d + i), col_ptr);
		end
	endtask : t_page_read
	task automatic t_protect;
		wp_n = 1'b0;
		send(REQ_CMD, OP_PROG);
		chk("prog protected", 1'b1, err);
		send(REQ_CMD, OP_ERASE);
		chk("erase protected", 1'b1, err);
		wp_n = 1'b1;
		send(REQ_CMD, OP_ERASE);
		chk("erase open", 1'b0, err);
		send(REQ_CMD, OP_PROG);
		send(REQ_WRITE, 8'h5a);
		chk("data in taken", 1'b0, err);
		chk("data in on bus", 8'h5a, last_din);
	endtask : t_protect
	task automatic t_decode;
		foreach (ops[i]) begin
			send(REQ_CMD, ops[i]);
			chk("opcode taken", 1'b0, err);
			chk("opcode on bus", ops[i], last_cmd);
		end
		send(REQ_CMD, 8'h42);
		chk("undefined", 1'b1, err);
		chk("undefined kept", 8'hd1, last_cmd);
		chk("refused level", 1'b1, cmd_refused);
	endtask : t_decode
	task automatic t_plane_ops;
		req_row = 18'h00000;
		send(REQ_CMD, OP_READ_COPYBACK);
		req_row = 18'h00040;
		send(REQ_CMD, OP_COPY_PROG);
		chk("copy other plane", 1'b1, err);
		chk("copy refused", 1'b1, cmd_refused);
		req_row = 18'h00000;
		send(REQ_CMD, OP_COPY_PROG);
		chk("copy same plane", 1'b0, err);
		chk("refused cleared", 1'b0, cmd_refused);
		send(REQ_CMD, OP_PLANE_CLOSE);
		send(REQ_CMD, OP_COPY_PROG);
		send(REQ_CMD, OP_PROG_CONFIRM);
		chk("two plane copy", 8'h10, last_cmd);
		send(REQ_CMD, OP_ERASE);
		send(REQ_CMD, OP_ERASE_PLANE);
		chk("erase plane pair", 8'hd1, last_cmd);
		send(REQ_CMD, OP_ERASE);
		send(REQ_CMD, OP_ERASE_CONFIRM);
		chk("erase two plane", 8'hd0, last_cmd);
		send(REQ_CMD, OP_PROG);
		send(REQ_CMD, OP_PLANE_CLOSE);
		send(REQ_CMD, OP_PROG_2ND);
		send(REQ_CMD, OP_CACHE_PROG);
		chk("two plane cache", 8'h15, last_cmd);
		send(REQ_CMD, OP_PLANE_CHANGE);
		send(REQ_CMD, OP_COL_CONFIRM);
		chk("plane change", 8'he0, last_cmd);
		chk("plane ops taken", 1'b0, err);
	endtask : t_plane_ops
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			bad_count++;
			complete_run();
		end
	end
	initial begin
		rst_n = 1'b0;
		req_valid = 1'b0;
		req_kind = REQ_CMD;
		req_data = 8'h00;
		req_col = 12'h000;
		req_row = 18'h00000;
		wp_n = 1'b1;
		repeat (3) @(negedge clock);
		rst_n = 1'b1;
		t_idle();
		t_page_read();
		t_protect();
		t_decode();
		t_plane_ops();
		complete_run();
	end
endmodule : nch_host_tb
`default_nettype wire

/* File: nch_pkg.sv */
// Package: opcodes, address layout and timing counts for the NAND host
package nch_pkg;
	localparam logic [7:0] OP_READ_SETUP = 8'h00;
	localparam logic [7:0] OP_READ_CONFIRM = 8'h30;
	localparam logic [7:0] OP_READ_COPYBACK = 8'h35;
	localparam logic [7:0] OP_CACHE_SEQ = 8'h31;
	localparam logic [7:0] OP_CACHE_END = 8'h3f;
	localparam logic [7:0] OP_COL_CHANGE = 8'h05;
	localparam logic [7:0] OP_PLANE_CHANGE = 8'h06;
	localparam logic [7:0] OP_COL_CONFIRM = 8'he0;
	localparam logic [7:0] OP_READ_ID = 8'h90;
	localparam logic [7:0] OP_PARAM_PAGE = 8'hec;
	localparam logic [7:0] OP_UNIQUE_ID = 8'hed;
	localparam logic [7:0] OP_GET_FEAT = 8'hee;
	localparam logic [7:0] OP_SET_FEAT = 8'hef;
	localparam logic [7:0] OP_STATUS = 8'h70;
	localparam logic [7:0] OP_STATUS_ENH = 8'h78;
	localparam logic [7:0] OP_RESET = 8'hff;
	localparam logic [7:0] OP_PROG = 8'h80;
	localparam logic [7:0] OP_PROG_2ND = 8'h81;
	localparam logic [7:0] OP_COPY_PROG = 8'h85;
	localparam logic [7:0] OP_PROG_CONFIRM = 8'h10;
	localparam logic [7:0] OP_PLANE_CLOSE = 8'h11;
	localparam logic [7:0] OP_CACHE_PROG = 8'h15;
	localparam logic [7:0] OP_ERASE = 8'h60;
	localparam logic [7:0] OP_ERASE_CONFIRM = 8'hd0;
	localparam logic [7:0] OP_ERASE_PLANE = 8'hd1;
	// Address layout
	localparam int COL_W = 12;
	localparam int ROW_W = 18;
	localparam int ADDR_CYCLES = 5;
	localparam int COL_CYCLES = 2;
	localparam int PLANE_BIT_ROW = 6;
	localparam logic [11:0] PAGE_LAST_COL = 12'h83f;
	// Bus phase timing (ns) and derived counts at 4 ns
	localparam int CLK_NS = 4;
	localparam int STROBE_LOW_NS = 12;
	localparam int STROBE_HIGH_NS = 10;
	localparam int LOW_CYC = (STROBE_LOW_NS + CLK_NS - 1) / CLK_NS;
	localparam int HIGH_CYC = (STROBE_HIGH_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [3:0] LOW_CNT = 4'(LOW_CYC);
	localparam logic [3:0] HIGH_CNT = 4'(HIGH_CYC);
	// Host request kinds
	localparam logic [1:0] REQ_CMD = 2'h0;
	localparam logic [1:0] REQ_ADDR = 2'h1;
	localparam logic [1:0] REQ_READ = 2'h2;
	localparam logic [1:0] REQ_WRITE = 2'h3;
	typedef enum logic [3:0] {
		NCH_IDLE = 4'b0001,
		NCH_SETUP = 4'b0010,
		NCH_HOLD = 4'b0100,
		NCH_DONE = 4'b1000
	} nch_state_t;
	// Opcodes that set up address cycles
	function automatic logic nch_takes_addr(input logic [7:0] op);
		return op == OP_READ_SETUP || op == OP_PROG || op == OP_PROG_2ND
			|| op == OP_COPY_PROG || op == OP_ERASE || op == OP_COL_CHANGE
			|| op == OP_PLANE_CHANGE || op == OP_READ_ID
			|| op == OP_PARAM_PAGE || op == OP_UNIQUE_ID
			|| op == OP_GET_FEAT || op == OP_SET_FEAT
			|| op == OP_STATUS_ENH;
	endfunction : nch_takes_addr
	// Program, erase and set-features opcodes, refused under write protect
	function automatic logic nch_is_write_op(input logic [7:0] op);
		return op == OP_PROG || op == OP_PROG_2ND || op == OP_COPY_PROG
			|| op == OP_ERASE || op == OP_ERASE_PLANE
			|| op == OP_PROG_CONFIRM || op == OP_PLANE_CLOSE
			|| op == OP_CACHE_PROG || op == OP_ERASE_CONFIRM
			|| op == OP_SET_FEAT;
	endfunction : nch_is_write_op
	// Opcodes legal while the device reports busy
	function automatic logic nch_busy_ok(input logic [7:0] op);
		return op == OP_STATUS || op == OP_STATUS_ENH || op == OP_RESET;
	endfunction : nch_busy_ok
	// Every opcode the device defines
	function automatic logic nch_known(input logic [7:0] op);
		return nch_takes_addr(op) || nch_is_write_op(op) || nch_busy_ok(op)
			|| op == OP_READ_CONFIRM || op == OP_READ_COPYBACK
			|| op == OP_CACHE_SEQ || op == OP_CACHE_END
			|| op == OP_COL_CONFIRM;
	endfunction : nch_known
endpackage : nch_pkg
